// [rtl/fwu_cfg.svh]
`ifndef FWU_CFG_SVH
`define FWU_CFG_SVH

// register indices; byte address is four times the index
`define FWU_IDX_CTRL   4'h0
`define FWU_IDX_ALOW   4'h1
`define FWU_IDX_AHIGH  4'h2
`define FWU_IDX_D0L    4'h3
`define FWU_IDX_D3H    4'ha
`define FWU_IDX_NONE   4'hf

// control register fields
`define FWU_B_WEN      7
`define FWU_F_MODE_HI  6
`define FWU_F_MODE_LO  4
`define FWU_B_UPE      3
`define FWU_B_WST      2
`define FWU_B_RDEN     1
`define FWU_B_RD       0

// reset values
`define FWU_RST_BYTE   8'h00
`define FWU_RST_ADDR   15'h0000

// key bytes, data1 low in the low byte up to data3 high
`define FWU_KEY        48'h40c3090d0400

// unlock timeout
`define FWU_TIMEOUT_US 300
`define FWU_SUB_HZ     32000
`define FWU_US_PER_S   1000000

`endif

// [rtl/fwu_pkg.sv]
package fwu_pkg;

   typedef enum logic [2:0] {
      FWU_MODE_WRITE  = 3'b000,
      FWU_MODE_ERASE  = 3'b001,
      FWU_MODE_READ   = 3'b011,
      FWU_MODE_UNLOCK = 3'b110
   } fwu_mode_t;

   typedef enum logic [1:0] {
      FWU_PH_IDLE   = 2'b00,
      FWU_PH_UNLOCK = 2'b01,
      FWU_PH_BUSY   = 2'b10
   } fwu_phase_t;

   typedef enum logic [1:0] {
      FWU_OP_WRITE = 2'b00,
      FWU_OP_ERASE = 2'b01,
      FWU_OP_READ  = 2'b11
   } fwu_op_t;

   // flash-side request bundle
   typedef struct packed {
      logic        req;
      fwu_op_t     op;
      logic [14:0] addr;
      logic [8:0]  page;
   } fwu_flash_req_t;

   // whole block state
   typedef struct packed {
      logic            ack;
      logic [31:0]     rdat;
      logic            wen;
      fwu_mode_t       mode;
      logic            upe;
      logic            wst;
      logic            rden;
      logic            rd;
      logic [14:0]     addr;
      logic [7:0][7:0] dat;
      logic [15:0]     wbuf;
      logic            wbuf_load;
      fwu_phase_t      phase;
      fwu_op_t         op;
      logic [15:0]     tcnt;
      logic            sub_s1;
      logic            sub_s2;
      logic            sub_s3;
   } fwu_state_t;

endpackage

// [rtl/fwu_top.sv]
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fwu_cfg.svh"

module fwu_top #(
   parameter int SUB_HZ = `FWU_SUB_HZ,
   parameter int TO_US  = `FWU_TIMEOUT_US
) (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // wishbone slave
   input  wire logic                    cyc_i,
   input  wire logic                    stb_i,
   input  wire logic                    we_i,
   input  wire logic [5:0]              adr_i,
   input  wire logic [3:0]              sel_i,
   input  wire logic [31:0]             dat_i,
   output logic [31:0]                  dat_o,
   output logic                         ack_o,
   // low-speed sub clock, asynchronous
   input  wire logic                    sub_clk_i,
   // flash array side
   output fwu_pkg::fwu_flash_req_t      flash_o,
   output logic [15:0]                  wbuf_data_o,
   output logic                         wbuf_load_o,
   output logic                         write_enabled_o,
   input  wire logic                    flash_done_i,
   input  wire logic [15:0]             flash_rdata_i
);

   // sub clock ticks in one timeout; rounded down, never below one
   localparam int TO_RAW   = (TO_US * SUB_HZ) / `FWU_US_PER_S;
   localparam int TO_TICKS = (TO_RAW < 1) ? 1 : TO_RAW;
   localparam logic [15:0] TO_LAST = 16'(TO_TICKS - 1);

   fwu_pkg::fwu_state_t s_r;
   fwu_pkg::fwu_state_t s_nxt;

   logic        req;
   logic        wr_commit;
   logic [3:0]  widx;
   logic [7:0]  wb;
   logic        sub_rise;
   logic [47:0] key_seen;
   logic        key_ok;
   logic [14:0] addr_inc;
   logic [2:0]  didx;

   function automatic logic [3:0] reg_index(input logic [5:0] a);
      if (a[1:0] != 2'b00 || a[5:2] > `FWU_IDX_D3H) begin
         reg_index = `FWU_IDX_NONE;
      end else begin
         reg_index = a[5:2];
      end
   endfunction

   function automatic logic [7:0] ctrl_byte(input fwu_pkg::fwu_state_t s);
      ctrl_byte = {s.wen, s.mode, s.upe, s.wst, s.rden, s.rd};
   endfunction

   assign req       = cyc_i & stb_i;
   // a write lands at the edge where the master sees ack
   assign wr_commit = req & s_r.ack & we_i & sel_i[0];
   assign widx      = reg_index(adr_i);
   assign wb        = dat_i[7:0];
   assign sub_rise  = s_r.sub_s2 & ~s_r.sub_s3;
   assign addr_inc  = s_r.addr + 15'h0001;
   // data byte slot; only indices 3..10 reach the data registers
   assign didx      = 3'(widx - `FWU_IDX_D0L);

   // compare all six key bytes, the last one as written now
   assign key_seen = {wb, s_r.dat[6], s_r.dat[5], s_r.dat[4], s_r.dat[3], s_r.dat[2]};
   assign key_ok   = (key_seen == `FWU_KEY);

   always_comb begin
      logic [7:0] rbyte;
      logic [2:0] nmode;
      logic       start_unlock;
      logic       key_done;
      logic       sw_wst;
      logic       sw_rd;
      rbyte        = `FWU_RST_BYTE;
      nmode        = wb[`FWU_F_MODE_HI:`FWU_F_MODE_LO];
      start_unlock = 1'b0;
      key_done     = 1'b0;
      sw_wst       = 1'b0;
      sw_rd        = 1'b0;
      s_nxt        = s_r;
      s_nxt.wbuf_load = 1'b0;

      // sub clock passes two flops before the edge detector
      s_nxt.sub_s1 = sub_clk_i;
      s_nxt.sub_s2 = s_r.sub_s1;
      s_nxt.sub_s3 = s_r.sub_s2;

      // bus handshake: ack one cycle after the request, dropped after
      s_nxt.ack = req & ~s_r.ack;
      if (req & ~s_r.ack & ~we_i) begin
         case (widx)
            `FWU_IDX_CTRL:  rbyte = ctrl_byte(s_r);
            `FWU_IDX_ALOW:  rbyte = s_r.addr[7:0];
            `FWU_IDX_AHIGH: rbyte = {1'b0, s_r.addr[14:8]};
            `FWU_IDX_NONE:  rbyte = `FWU_RST_BYTE;
            default:        rbyte = s_r.dat[didx];
         endcase
         s_nxt.rdat = {24'h000000, rbyte};
      end

      if (wr_commit) begin
         case (widx)
            `FWU_IDX_CTRL: begin
               // a one written into the flag is ignored
               if (!wb[`FWU_B_WEN]) begin
                  s_nxt.wen = 1'b0;
               end
               s_nxt.mode = fwu_pkg::fwu_mode_t'(nmode);
               s_nxt.rden = wb[`FWU_B_RDEN];
               // enable accepted in the same write as the mode
               s_nxt.upe  = wb[`FWU_B_UPE];
               // start bits can only be set by software
               sw_wst = wb[`FWU_B_WST];
               sw_rd  = wb[`FWU_B_RD];
               // unlock begins on mode 110 with enable set
               if (wb[`FWU_B_UPE] && nmode == fwu_pkg::FWU_MODE_UNLOCK &&
                   s_r.phase == fwu_pkg::FWU_PH_IDLE) begin
                  start_unlock = 1'b1;
               end
            end
            `FWU_IDX_ALOW: begin
               s_nxt.addr[7:0] = wb;
            end
            `FWU_IDX_AHIGH: begin
               s_nxt.addr[14:8] = wb[6:0];
            end
            `FWU_IDX_NONE: begin
               s_nxt.addr = s_r.addr;
            end
            default: begin
               // data bytes, fourth word high byte included
               s_nxt.dat[didx] = wb;
               // first word high byte feeds the write buffer
               if (widx == `FWU_IDX_D0L + 4'h1) begin
                  s_nxt.wbuf      = {wb, s_r.dat[0]};
                  s_nxt.wbuf_load = 1'b1;
                  s_nxt.addr      = addr_inc;
               end
               if (widx == `FWU_IDX_D3H) begin
                  key_done = 1'b1;
               end
            end
         endcase
      end

      case (s_r.phase)
         fwu_pkg::FWU_PH_IDLE: begin
            if (start_unlock) begin
               // timeout starts afresh with each procedure
               s_nxt.phase = fwu_pkg::FWU_PH_UNLOCK;
               s_nxt.tcnt  = 16'h0000;
            end else if (s_r.wst) begin
               // write and erase refused while locked
               if (!s_r.wen || (s_r.mode != fwu_pkg::FWU_MODE_WRITE &&
                                s_r.mode != fwu_pkg::FWU_MODE_ERASE)) begin
                  s_nxt.wst = 1'b0;
               end else begin
                  s_nxt.phase = fwu_pkg::FWU_PH_BUSY;
                  s_nxt.op    = (s_r.mode == fwu_pkg::FWU_MODE_ERASE) ?
                                fwu_pkg::FWU_OP_ERASE : fwu_pkg::FWU_OP_WRITE;
               end
            end else if (s_r.rd) begin
               if (s_r.rden && s_r.mode == fwu_pkg::FWU_MODE_READ) begin
                  s_nxt.phase = fwu_pkg::FWU_PH_BUSY;
                  s_nxt.op    = fwu_pkg::FWU_OP_READ;
               end else begin
                  s_nxt.rd = 1'b0;
               end
            end
         end
         fwu_pkg::FWU_PH_UNLOCK: begin
            if (!s_nxt.upe) begin
               // software withdrew the enable; procedure abandoned
               s_nxt.phase = fwu_pkg::FWU_PH_IDLE;
            end else if (key_done) begin
               s_nxt.phase = fwu_pkg::FWU_PH_IDLE;
               if (key_ok) begin
                  // correct key in time enables writing
                  // flag set by hardware, wins over a clear
                  s_nxt.wen = 1'b1;
               end else begin
                  // wrong key ends the attempt, still locked
                  s_nxt.upe = 1'b0;
               end
            end else if (sub_rise) begin
               if (s_r.tcnt == TO_LAST) begin
                  s_nxt.upe   = 1'b0;
                  s_nxt.phase = fwu_pkg::FWU_PH_IDLE;
               end else begin
                  s_nxt.tcnt = s_r.tcnt + 16'h0001;
               end
            end
         end
         fwu_pkg::FWU_PH_BUSY: begin
            if (flash_done_i) begin
               s_nxt.phase = fwu_pkg::FWU_PH_IDLE;
               if (s_r.op == fwu_pkg::FWU_OP_READ) begin
                  s_nxt.rd     = 1'b0;
                  s_nxt.dat[0] = flash_rdata_i[7:0];
                  s_nxt.dat[1] = flash_rdata_i[15:8];
               end else begin
                  // hardware clears write start on completion
                  s_nxt.wst = 1'b0;
               end
            end
         end
         default: begin
            s_nxt.phase = fwu_pkg::FWU_PH_IDLE;
         end
      endcase

      // a start written in the cycle that ends or refuses the last one still counts
      if (sw_wst) begin
         s_nxt.wst = 1'b1;
      end
      if (sw_rd) begin
         s_nxt.rd = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // flash side; an erase spans 64 words so the low six bits are dropped
   always_comb begin
      flash_o.req  = (s_r.phase == fwu_pkg::FWU_PH_BUSY);
      flash_o.op   = s_r.op;
      flash_o.addr = s_r.addr;
      // one request clears a whole page of 64 words
      // page from high address and low bits 7..6 only
      // page is high times four plus low bits 7..6
      flash_o.page = {s_r.addr[14:8], s_r.addr[7:6]};
   end

   assign dat_o           = s_r.rdat;
   assign ack_o           = s_r.ack;
   assign wbuf_data_o     = s_r.wbuf;
   assign wbuf_load_o     = s_r.wbuf_load;
   assign write_enabled_o = s_r.wen;

endmodule

`default_nettype wire

// [tb/fwu_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module fwu_top_asserts #(
   parameter int SUB_HZ = 32000,
   parameter int TO_US  = 300
) (
   input wire logic                    clk_i, rst_i, cyc_i, stb_i, we_i,
   input wire logic [5:0]              adr_i,
   input wire logic [3:0]              sel_i,
   input wire logic [31:0]             dat_i,
   input wire logic                    ack_o, flash_done_i, wbuf_load_o, write_enabled_o,
   input wire fwu_pkg::fwu_flash_req_t flash_o
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic wr, ctl, k3;
   assign wr  = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
   assign ctl = wr && adr_i == 6'h00;
   assign k3  = wr && adr_i == 6'h28;
   AST_ACK_TAKE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acknowledged");
   AST_ACK_ONE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_REQ_LOCK: assert property (
      $rose(flash_o.req) && flash_o.op != fwu_pkg::FWU_OP_READ |-> write_enabled_o)
      else $error("flash change while locked");
   AST_PAGE: assert property (
      flash_o.req && flash_o.op == fwu_pkg::FWU_OP_ERASE |-> flash_o.page == flash_o.addr[14:6])
      else $error("erase page wrong");
   AST_REQ_HOLD: assert property (flash_o.req && !flash_done_i |=> flash_o.req)
      else $error("request dropped early");
   AST_REQ_END: assert property (flash_o.req && flash_done_i |=> !flash_o.req)
      else $error("request not ended");
   AST_WBUF_LOAD: assert property (wr && adr_i == 6'h10 |-> ##[1:2] wbuf_load_o)
      else $error("write buffer not loaded");
   AST_WBUF_ONE: assert property (wbuf_load_o |=> !wbuf_load_o)
      else $error("load pulse too long");
   AST_FLAG_SET: assert property ($rose(write_enabled_o) |-> $past(k3, 2))
      else $error("flag set without key");
   AST_FLAG_CLR: assert property (
      ctl && (!dat_i[7] || !write_enabled_o) |-> ##2 !write_enabled_o)
      else $error("flag not clear");
   cover property ($rose(write_enabled_o));
   cover property (flash_o.req && flash_o.op == fwu_pkg::FWU_OP_ERASE);
   cover property (wbuf_load_o);
endmodule
`default_nettype wire

// [tb/fwu_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwu_cfg.svh"
module fwu_top_tb_top;
   localparam int SUB_HZ = 10000;
   localparam int TO_US  = 300;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic sub_clk_i = 1'b0, flash_done_i = 1'b0, ack_o, wbuf_load_o, write_enabled_o;
   logic [5:0]  adr_i = 6'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [15:0] flash_rdata_i = 16'h0, wbuf_data_o, rv;
   logic [14:0] a;
   logic [7:0]  al, ah, b;
   fwu_pkg::fwu_flash_req_t flash_o;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   always #25 clk_i = ~clk_i;
   // sub clock edges fall on falling edges of the system clock
   always #50000 sub_clk_i = ~sub_clk_i;
   fwu_top #(.SUB_HZ(SUB_HZ), .TO_US(TO_US)) i_fwu_top (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .sub_clk_i(sub_clk_i), .flash_o(flash_o), .wbuf_data_o(wbuf_data_o),
      .wbuf_load_o(wbuf_load_o), .write_enabled_o(write_enabled_o),
      .flash_done_i(flash_done_i), .flash_rdata_i(flash_rdata_i));
   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares = miscompares + 1;
         finish_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'h1;
      adr_i <= {i, 2'b00};
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] i, input logic [7:0] e);
      wb(1'b0, i, 8'h00);
      chk($sformatf("reg%0d", i), {24'h0, e}, q);
   endtask
   task automatic flag(input logic e);
      @(posedge clk_i);
      chk("flag", {31'h0, e}, {31'h0, write_enabled_o});
   endtask
   task automatic op_wait(input fwu_pkg::fwu_op_t o, input logic [8:0] pg, input logic [14:0] ad);
      while (flash_o.req !== 1'b1) @(posedge clk_i);
      chk("op", {30'h0, o}, {30'h0, flash_o.op});
      chk("addr", {17'h0, ad}, {17'h0, flash_o.addr});
      chk("page", {23'h0, pg}, {23'h0, flash_o.page});
      rv = 16'($urandom);
      flash_rdata_i <= rv;
      flash_done_i <= 1'b1;
      @(posedge clk_i);
      flash_done_i <= 1'b0;
   endtask
   task automatic unlock(input int bad, input int wt);
      wb(1'b1, 4'h0, 8'h68);
      for (int k = 0; k < 6; k++) begin
         if (k == 5) repeat (wt) @(posedge clk_i);
         wb(1'b1, 4'(5 + k), 8'(`FWU_KEY >> (8 * k)) ^ ((k == bad) ? 8'h5a : 8'h00));
      end
   endtask
   task automatic locked_erase();
      wb(1'b1, 4'h0, 8'h14);
      repeat (4) @(posedge clk_i);
      chk("req", 32'h0, {31'h0, flash_o.req});
      rd(4'h0, 8'h10);
   endtask
   initial begin
      void'($urandom(32706));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 12; i++) rd(4'(i), 8'h00);
      wb(1'b1, 4'hb, 8'h5a);
      rd(4'hb, 8'h00);
      for (int i = 5; i < 11; i++) begin
         b = 8'($urandom);
         wb(1'b1, 4'(i), b);
         rd(4'(i), b);
      end
      $display("test registers done");
      locked_erase();
      unlock($urandom_range(5), 0);
      rd(4'h0, 8'h60);
      unlock(-1, 7000);
      rd(4'h0, 8'h60);
      flag(1'b0);
      unlock(-1, 1000);
      rd(4'h0, 8'he8);
      $display("test unlock done");
      for (int i = 0; i < 4; i++) begin
         ah = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : {1'b0, 7'($urandom)};
         al = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         wb(1'b1, 4'h1, al);
         wb(1'b1, 4'h2, ah);
         wb(1'b1, 4'h0, 8'h94);
         op_wait(fwu_pkg::FWU_OP_ERASE, {ah[6:0], al[7:6]}, {ah[6:0], al});
         rd(4'h0, 8'h90);
      end
      b = 8'($urandom);
      wb(1'b1, 4'h3, b);
      wb(1'b1, 4'h4, ~b);
      @(posedge clk_i);
      chk("wbuf", {16'h0, ~b, b}, {16'h0, wbuf_data_o});
      a = {ah[6:0], al} + 15'h0001;
      rd(4'h1, a[7:0]);
      rd(4'h2, {1'b0, a[14:8]});
      wb(1'b1, 4'h0, 8'h84);
      op_wait(fwu_pkg::FWU_OP_WRITE, a[14:6], a);
      rd(4'h0, 8'h80);
      wb(1'b1, 4'h0, 8'hb3);
      op_wait(fwu_pkg::FWU_OP_READ, a[14:6], a);
      rd(4'h3, rv[7:0]);
      rd(4'h4, rv[15:8]);
      $display("test flash ops done");
      wb(1'b1, 4'h0, 8'h80);
      flag(1'b1);
      wb(1'b1, 4'h0, 8'h00);
      flag(1'b0);
      wb(1'b1, 4'h0, 8'h80);
      rd(4'h0, 8'h00);
      locked_erase();
      $display("test relock done");
      finish_test();
   end
endmodule
bind fwu_top fwu_top_asserts #(.SUB_HZ(SUB_HZ), .TO_US(TO_US)) i_fwu_top_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
   .flash_done_i(flash_done_i), .wbuf_load_o(wbuf_load_o),
   .write_enabled_o(write_enabled_o), .flash_o(flash_o));
`default_nettype wire
